// *** verilog/mfirq_ctrl.sv ***
/*
 Multi-function interrupt controller: group control register, sub-register bank,
 global enable, service handshake with the core, and a sticky status interrupt.
 Assumes a synchronous register port with one-cycle strobes and pulse events.
*/
// Our own choices: the register offsets and the address-and-strobe port.
// What this block does
// - Group 5, 4, 3 request flags live in bits 6, 5, 4 of group control.
// - Group 5, 4, 3 enables live in bits 2, 1, 0 of group control.
// - Unimplemented bits always read back as zero.
// - First sub-register: EEPROM flag bit 5, conversion-done flag bit 4.
// - First sub-register: EEPROM enable bit 1, conversion-done enable bit 0.
// - Second sub-register: periodic timer 0 compare A flag bit 5, P bit 4.
// - Second sub-register: periodic timer 0 compare A enable bit 1, P bit 0.
// - Third sub-register: standard timer 0 compare A flag bit 5, P bit 4.
// - Third sub-register: standard timer 0 compare A enable bit 1, P bit 0.
// - Fourth sub-register: serial 0 flag bit 6, enable bit 2.
// - Fourth sub-register: standard timer 1 flags bits 5, 4, enables 1, 0.
// - A source event sets its flag whatever its enable says.
// - Only an enabled pending request may raise a service request.
// - With the global enable low no interrupt is serviced.
// - Service entry clears the global enable; new events still latch.
`timescale 1ns/10ps
`default_nettype none

module mfirq_ctrl
    import mfirq_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [MFIRQ_AW-1:0] reg_addr,
    input wire logic [MFIRQ_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [MFIRQ_DW-1:0] reg_rdata,
    input wire logic eeprom_ev,
    input wire logic conv_done_ev,
    input wire logic ptimer0_cmpa_ev,
    input wire logic ptimer0_cmpp_ev,
    input wire logic stimer0_cmpa_ev,
    input wire logic stimer0_cmpp_ev,
    input wire logic serial0_ev,
    input wire logic stimer1_cmpa_ev,
    input wire logic stimer1_cmpp_ev,
    input wire logic core_ack,
    input wire logic core_reti,
    output logic core_irq_req,
    output logic [MFIRQ_NGRP-1:0] core_vector,
    output logic irq
);

    mfirq_sub_if sub_bus();

    mfirq_subregs u_subregs
    (
        .clock(clock),
        .rstn(rstn),
        .sub(sub_bus.regs)
    );

    mfirq_state_type st_q;
    mfirq_state_type st_d;
    logic [7:0] grp_q;
    logic [7:0] grp_d;
    logic gie_q;
    logic gie_d;
    logic [2:0] stat_q;
    logic [2:0] stat_d;
    logic [2:0] mask_q;
    logic [2:0] mask_d;
    logic [2:0] vec_q;
    logic [2:0] vec_d;
    logic req_q;
    logic req_d;
    logic irq_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // Register decode
    wire sel_grp = reg_addr == MFIRQ_OFS_GRP3;
    wire sel_ctrl = reg_addr == MFIRQ_OFS_CTRL;
    wire sel_stat = reg_addr == MFIRQ_OFS_STAT;
    wire sel_mask = reg_addr == MFIRQ_OFS_MASK;
    wire [3:0] sel_sub;
    wire wr_grp = reg_wr && sel_grp;
    wire wr_ctrl = reg_wr && sel_ctrl;
    wire wr_stat = reg_wr && sel_stat;
    wire wr_mask = reg_wr && sel_mask;

    genvar s;
    generate
        for (s = 0; s < MFIRQ_NSUB; s++)
        begin : g_sel
            assign sel_sub[s] = reg_addr == (MFIRQ_OFS_SUB0 + 8'(s));
        end
    endgenerate

    assign sub_bus.wr_sel = reg_wr ? sel_sub : 4'h0;
    assign sub_bus.wdata = reg_wdata;

    // Event pulses placed at their flag positions
    assign sub_bus.set_ev[0] = {2'b00, eeprom_ev, conv_done_ev, 4'h0};
    assign sub_bus.set_ev[1] = {2'b00, ptimer0_cmpa_ev, ptimer0_cmpp_ev, 4'h0};
    assign sub_bus.set_ev[2] = {2'b00, stimer0_cmpa_ev, stimer0_cmpp_ev, 4'h0};
    assign sub_bus.set_ev[3] = {1'b0, serial0_ev, stimer1_cmpa_ev, stimer1_cmpp_ev, 4'h0};

    // Group requests from the enabled sub-sources
    wire [2:0] grp_src;
    genvar k;
    generate
        for (k = 0; k < MFIRQ_NGRP; k++)
        begin : g_grp
            assign grp_src[k] = |(sub_bus.pend & MFIRQ_GRP_MAP[k]);
        end
    endgenerate

    wire [2:0] grp_flag = grp_q[MFIRQ_FLAG_LSB +: MFIRQ_SRC_W];
    wire [2:0] grp_en = grp_q[MFIRQ_EN_LSB +: MFIRQ_SRC_W];
    wire [2:0] grp_pend = grp_flag & grp_en;
    wire [2:0] grp_pick = grp_pend & (~grp_pend + 3'd1);
    wire any_pend = |grp_pend;

    // Handshake events
    wire in_idle = st_q == MFIRQ_IDLE;
    wire in_req = st_q == MFIRQ_REQ;
    wire in_serv = st_q == MFIRQ_SERV;
    wire still_valid = gie_q && (|(grp_pend & vec_q));
    wire entry = in_req && core_ack && still_valid;
    wire withdraw = in_req && !core_ack && !still_valid;
    wire leave = in_serv && core_reti;

    // Group 3 is the highest priority; entry acknowledges the chosen group flag
    wire [7:0] grp_ack_clr = entry ? {1'b0, vec_q, 4'h0} : 8'h00;
    wire [7:0] grp_base = wr_grp ? reg_wdata : grp_q;
    wire [7:0] grp_set = {1'b0, grp_src, 4'h0};
    assign grp_d = ((grp_base & ~grp_ack_clr) | grp_set) & MFIRQ_GRP_IMPL;

    // Entry clears the global enable over everything else; return restores it
    assign gie_d = entry ? 1'b0 : leave ? 1'b1 : wr_ctrl ? reg_wdata[MFIRQ_CTRL_GIE_BIT] : gie_q;

    always_comb
    begin
        st_d = st_q;
        vec_d = vec_q;
        req_d = req_q;
        unique case (st_q)
            MFIRQ_IDLE:
            begin
                if (gie_q && any_pend)
                begin
                    st_d = MFIRQ_REQ;
                    vec_d = grp_pick;
                    req_d = 1'b1;
                end
            end
            MFIRQ_REQ:
            begin
                if (entry)
                begin
                    st_d = MFIRQ_SERV;
                    req_d = 1'b0;
                end
                else if (withdraw || (core_ack && !still_valid))
                begin
                    st_d = MFIRQ_IDLE;
                    req_d = 1'b0;
                end
            end
            MFIRQ_SERV:
            begin
                if (core_reti)
                    st_d = MFIRQ_IDLE;
            end
            default:
            begin
                st_d = MFIRQ_IDLE;
                req_d = 1'b0;
            end
        endcase
    end

    // Sticky status: a group flag going high; set beats a write-one clear
    wire [2:0] stat_ev = grp_d[MFIRQ_FLAG_LSB +: MFIRQ_SRC_W] & ~grp_flag;
    wire [2:0] stat_clr = wr_stat ? reg_wdata[2:0] : 3'h0;
    assign stat_d = (stat_q & ~stat_clr) | stat_ev;
    assign mask_d = wr_mask ? reg_wdata[2:0] : mask_q;

    // Read mux; unmapped addresses answer zero
    wire [7:0] ctrl_val = {6'h00, in_serv, gie_q};
    wire [7:0] sub_val = sel_sub[0] ? sub_bus.value[0] :
                         sel_sub[1] ? sub_bus.value[1] :
                         sel_sub[2] ? sub_bus.value[2] :
                         sel_sub[3] ? sub_bus.value[3] : 8'h00;
    wire [7:0] rd_val = sel_grp ? grp_q :
                        sel_ctrl ? ctrl_val :
                        sel_stat ? {5'h00, stat_q} :
                        sel_mask ? {5'h00, mask_q} : sub_val;
    assign rdata_d = reg_rd ? rd_val : 8'h00;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= MFIRQ_IDLE;
            grp_q <= MFIRQ_RST;
            gie_q <= MFIRQ_GIE_RST;
            vec_q <= 3'h0;
            req_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            grp_q <= grp_d;
            gie_q <= gie_d;
            vec_q <= vec_d;
            req_q <= req_d;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            stat_q <= 3'h0;
            mask_q <= 3'h0;
            irq_q <= 1'b0;
            rdata_q <= 8'h00;
        end
        else
        begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q <= |(stat_d & mask_d);
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign core_irq_req = req_q;
    assign core_vector = vec_q;
    assign irq = irq_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    grp_flag_set_a: assert property (
        grp_src[2] |=> grp_q[6])
        else $error("group 5 flag not set by its request");

    grp_en_write_a: assert property (
        wr_grp |=> grp_q[2:0] == $past(reg_wdata[2:0]))
        else $error("group enables do not follow the write");

    grp_unimpl_read_a: assert property (
        reg_rd && sel_grp |=> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
        else $error("unimplemented group bits read non-zero");

    eeprom_conv_flag_a: assert property (
        (eeprom_ev |=> sub_bus.value[0][5]) and (conv_done_ev |=> sub_bus.value[0][4]))
        else $error("eeprom or conversion flag not set");

    eeprom_conv_en_a: assert property (
        reg_wr && sel_sub[0] |=> sub_bus.value[0][1:0] == $past(reg_wdata[1:0]))
        else $error("eeprom or conversion enable not written");

    ptimer_flag_a: assert property (
        ptimer0_cmpa_ev |=> sub_bus.value[1][5])
        else $error("periodic timer compare A flag not set");

    ptimer_en_a: assert property (
        reg_wr && sel_sub[1] |=> sub_bus.value[1][1:0] == $past(reg_wdata[1:0]))
        else $error("periodic timer enables not written");

    stimer0_flag_a: assert property (
        (stimer0_cmpa_ev |=> sub_bus.value[2][5]) and (stimer0_cmpp_ev |=> sub_bus.value[2][4]))
        else $error("standard timer 0 compare flag not set");

    stimer0_en_a: assert property (
        reg_wr && sel_sub[2] |=> sub_bus.value[2][1:0] == $past(reg_wdata[1:0]))
        else $error("standard timer 0 enables not written");

    serial_bits_a: assert property (
        reg_wr && sel_sub[3] |=> sub_bus.value[3][2] == $past(reg_wdata[2]))
        else $error("serial enable not written");

    stimer1_flag_a: assert property (
        stimer1_cmpp_ev |=> sub_bus.value[3][4])
        else $error("standard timer 1 compare P flag not set");

    req_needs_pend_a: assert property (
        $rose(core_irq_req) |-> $past(any_pend) && $past(gie_q))
        else $error("service request without enabled pending group");

    gie_blocks_a: assert property (
        in_idle && !gie_q ##1 !gie_q |-> !$rose(core_irq_req))
        else $error("service request raised with global enable low");

    entry_clears_gie_a: assert property (
        entry |=> !gie_q && in_serv [*1] ##0 !core_irq_req)
        else $error("global enable not cleared on service entry");

    group_from_sub_a: assert property (
        sub_bus.pend[0] |=> grp_q[4])
        else $error("group 3 not requested by its sub-register");

    entry_c: cover property (entry);
    reti_c: cover property (in_serv ##[1:20] leave);
    blocked_latch_c: cover property (in_serv && stimer1_cmpa_ev);
    irq_rise_c: cover property ($rose(irq));

endmodule

`default_nettype wire

// *** verilog/mfirq_pkg.sv ***
/*
 Constants for the multi-function interrupt register block: register offsets,
 field positions, implemented-bit masks, reset values and controller states.
 Assumes an 8-bit register port and three multi-function groups.
*/
`default_nettype none

package mfirq_pkg;

    localparam int MFIRQ_AW = 8;
    localparam int MFIRQ_DW = 8;
    localparam int MFIRQ_NSUB = 4;
    localparam int MFIRQ_NGRP = 3;

    localparam logic [7:0] MFIRQ_OFS_GRP3 = 8'h00;
    localparam logic [7:0] MFIRQ_OFS_SUB0 = 8'h01;
    localparam logic [7:0] MFIRQ_OFS_CTRL = 8'h05;
    localparam logic [7:0] MFIRQ_OFS_STAT = 8'h06;
    localparam logic [7:0] MFIRQ_OFS_MASK = 8'h07;

    // Flags sit in the upper nibble, enables in the lower, same order
    localparam int MFIRQ_FLAG_LSB = 4;
    localparam int MFIRQ_EN_LSB = 0;
    localparam int MFIRQ_SRC_W = 3;

    localparam logic [7:0] MFIRQ_GRP_IMPL = 8'h77;
    localparam logic [3:0][7:0] MFIRQ_SUB_IMPL = {8'h77, 8'h33, 8'h33, 8'h33};
    localparam logic [7:0] MFIRQ_RST = 8'h00;

    // Group k collects the sub-registers whose bits are set in entry k
    localparam logic [2:0][3:0] MFIRQ_GRP_MAP = {4'h8, 4'h6, 4'h1};

    localparam int MFIRQ_CTRL_GIE_BIT = 0;
    localparam int MFIRQ_CTRL_BUSY_BIT = 1;
    localparam logic MFIRQ_GIE_RST = 1'b0;

    typedef enum logic [2:0]
    {
        MFIRQ_IDLE = 3'b001,
        MFIRQ_REQ = 3'b010,
        MFIRQ_SERV = 3'b100
    } mfirq_state_type;

endpackage

`default_nettype wire

// *** verilog/mfirq_sub_if.sv ***
/*
 Carrier between the controller and the sub-register bank.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

interface mfirq_sub_if;
    logic [3:0] wr_sel;
    logic [7:0] wdata;
    logic [3:0][7:0] set_ev;
    logic [3:0][7:0] value;
    logic [3:0] pend;

    modport regs
    (
        input wr_sel,
        input wdata,
        input set_ev,
        output value,
        output pend
    );

    modport ctl
    (
        output wr_sel,
        output wdata,
        output set_ev,
        input value,
        input pend
    );
endinterface

`default_nettype wire

// *** verilog/mfirq_subregs.sv ***
/*
 Bank of the four multi-function sub-registers: flag and enable bits per source.
 Assumes single-cycle write selects and one-cycle event pulses in flag positions.
*/
`timescale 1ns/10ps
`default_nettype none

module mfirq_subregs
    import mfirq_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    mfirq_sub_if.regs sub
);

    genvar g;
    generate
        for (g = 0; g < MFIRQ_NSUB; g++)
        begin : g_sub
            logic [7:0] val_q;
            logic [7:0] val_d;
            logic [7:0] base;

            // A hardware set is ORed last so it beats a software clear
            assign base = sub.wr_sel[g] ? sub.wdata : val_q;
            assign val_d = (base | sub.set_ev[g]) & MFIRQ_SUB_IMPL[g];
            assign sub.value[g] = val_q;
            assign sub.pend[g] = |(val_q[MFIRQ_FLAG_LSB +: MFIRQ_SRC_W]
                & val_q[MFIRQ_EN_LSB +: MFIRQ_SRC_W]);

            always_ff @(posedge clock or negedge rstn)
            begin
                if (!rstn)
                    val_q <= MFIRQ_RST;
                else
                    val_q <= val_d;
            end

            sub_flag_set_a: assert property (
                @(posedge clock) disable iff (!rstn)
                (sub.set_ev[g] != 8'h00) |=> ((val_q & $past(sub.set_ev[g])) == $past(sub.set_ev[g])))
                else $error("sub flag not set by its event");

            sub_unimpl_zero_a: assert property (
                @(posedge clock) disable iff (!rstn)
                (val_q & ~MFIRQ_SUB_IMPL[g]) == 8'h00)
                else $error("unimplemented sub bit is not zero");
        end
    endgenerate

endmodule

`default_nettype wire

// *** sim/multifunction_irq_regs_test.sv ***
/*
 Self-checking bench for the multi-function interrupt controller.
 Assumes mfirq_pkg, the carrier interface and both design modules compile first.
*/
`timescale 1ns/10ps
`default_nettype none

module multifunction_irq_regs_test
    import mfirq_pkg::*;
();
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [8:0] ev_q = 9'h000;
    logic core_ack = 1'b0;
    logic core_reti = 1'b0;
    logic core_irq_req;
    logic [2:0] core_vector;
    logic irq;
    int failures = 0;
    int compares = 0;
    int seed = 32'h057f36e1;
    int sub_m[4] = '{0, 0, 0, 0};
    int grp_m = 0;
    // Event order matches the ev_q bits wired below
    int ev_addr[9] = '{1, 1, 2, 2, 3, 3, 4, 4, 4};
    int ev_bit[9] = '{5, 4, 5, 4, 5, 4, 6, 5, 4};
    int sub_impl[4] = '{8'h33, 8'h33, 8'h33, 8'h77};

    mfirq_ctrl i_dut
    (
        .clock(clock),
        .rstn(rstn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .eeprom_ev(ev_q[0]),
        .conv_done_ev(ev_q[1]),
        .ptimer0_cmpa_ev(ev_q[2]),
        .ptimer0_cmpp_ev(ev_q[3]),
        .stimer0_cmpa_ev(ev_q[4]),
        .stimer0_cmpp_ev(ev_q[5]),
        .serial0_ev(ev_q[6]),
        .stimer1_cmpa_ev(ev_q[7]),
        .stimer1_cmpp_ev(ev_q[8]),
        .core_ack(core_ack),
        .core_reti(core_reti),
        .core_irq_req(core_irq_req),
        .core_vector(core_vector),
        .irq(irq)
    );

    initial
    begin
        forever #12.5 clock = ~clock;
    end

    task automatic summarize();
        if (failures == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input int exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        chk(name, reg_rdata, exp[7:0]);
    endtask

    task automatic pulse(input int i);
        @(posedge clock);
        ev_q <= 9'h001 << i;
        @(posedge clock);
        ev_q <= 9'h000;
    endtask

    task automatic core_pulse(input bit is_ack);
        @(posedge clock);
        core_ack <= is_ack;
        core_reti <= !is_ack;
        @(posedge clock);
        core_ack <= 1'b0;
        core_reti <= 1'b0;
        @(negedge clock);
    endtask

    // Bounded so a request that never comes is reported, not waited on
    task automatic wait_req(input logic lvl);
        int n;
        n = 0;
        while (core_irq_req !== lvl && n < 20)
        begin
            @(negedge clock);
            n++;
        end
        chk("core_irq_req", {7'h00, core_irq_req}, {7'h00, lvl});
    endtask

    // Group flags that hardware raises from enabled, pending sub-sources
    function automatic int gpend();
        int p;
        p = 0;
        if ((((sub_m[0] >> 4) & sub_m[0]) & 3) != 0)
            p = p | 8'h10;
        if (((((sub_m[1] >> 4) & sub_m[1]) | ((sub_m[2] >> 4) & sub_m[2])) & 3) != 0)
            p = p | 8'h20;
        if ((((sub_m[3] >> 4) & sub_m[3]) & 7) != 0)
            p = p | 8'h40;
        return p;
    endfunction

    initial
    begin
        repeat (20000) @(posedge clock);
        failures++;
        summarize();
    end

    initial
    begin
        int a;
        logic [7:0] v;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        // Stray handshake pulses outside a service must change nothing
        core_pulse(1'b1);
        core_pulse(1'b0);
        for (int i = 0; i < 9; i++)
            rchk("reset value", i[7:0], 0);
        wr(8'h20, 8'hff);
        rchk("unmapped", 8'h20, 0);
        // Global enable stays low, so no request may reach the core here
        for (int n = 0; n < 40; n++)
        begin
            a = {$random(seed)} % 5;
            v = 8'($random(seed));
            wr(a[7:0], v);
            if (a == 0)
                grp_m = (v & 8'h77) | gpend();
            else
            begin
                sub_m[a - 1] = v & sub_impl[a - 1];
                grp_m = grp_m | gpend();
                rchk("sub register", a[7:0], sub_m[a - 1]);
            end
            rchk("group register", 8'h00, grp_m);
            chk("core_irq_req", {7'h00, core_irq_req}, 8'h00);
        end
        for (int i = 1; i < 5; i++)
            wr(i[7:0], 8'h00);
        wr(MFIRQ_OFS_GRP3, 8'h00);
        wr(MFIRQ_OFS_STAT, 8'h07);
        for (int i = 0; i < 9; i++)
        begin
            pulse(i);
            rchk("event flag", ev_addr[i][7:0], 1 << ev_bit[i]);
            rchk("group register", 8'h00, 0);
            wr(ev_addr[i][7:0], 8'h00);
        end
        wr(MFIRQ_OFS_MASK, 8'h07);
        wr(8'h01, 8'h02);
        wr(MFIRQ_OFS_GRP3, 8'h07);
        wr(MFIRQ_OFS_CTRL, 8'h01);
        pulse(0);
        wait_req(1'b1);
        chk("core_vector", {5'h00, core_vector}, 8'h01);
        chk("irq", {7'h00, irq}, 8'h01);
        rchk("group register", 8'h00, 8'h17);
        rchk("status", MFIRQ_OFS_STAT, 8'h01);
        core_pulse(1'b1);
        chk("core_irq_req", {7'h00, core_irq_req}, 8'h00);
        rchk("control", MFIRQ_OFS_CTRL, 8'h02);
        pulse(7);
        rchk("latched flag", 8'h04, 8'h20);
        chk("core_irq_req", {7'h00, core_irq_req}, 8'h00);
        core_pulse(1'b0);
        rchk("control", MFIRQ_OFS_CTRL, 8'h01);
        wait_req(1'b1);
        chk("core_vector", {5'h00, core_vector}, 8'h01);
        wr(MFIRQ_OFS_MASK, 8'h00);
        rchk("status", MFIRQ_OFS_STAT, 8'h01);
        chk("irq", {7'h00, irq}, 8'h00);
        wr(MFIRQ_OFS_STAT, 8'h07);
        wr(MFIRQ_OFS_MASK, 8'h07);
        rchk("status", MFIRQ_OFS_STAT, 8'h00);
        chk("irq", {7'h00, irq}, 8'h00);
        // Dropping the source and the group flag withdraws the pending request
        wr(8'h01, 8'h00);
        wr(MFIRQ_OFS_GRP3, 8'h07);
        wait_req(1'b0);
        summarize();
    end
endmodule

`default_nettype wire
